//--- hw/adcrf_core.sv
`timescale 1ns/1ps

// Summary of operation
// - Two-bit format field picks four layouts: three 32-bit, one 24-bit.
// - Upper format bit zero: 24-bit two's complement code, shifted out MSB first.
// - 24-bit codings clamp positive overflow at 0x7FFFFF.
// - 24-bit codings clamp negative overflow at 0x800000.
// - Format 00 gives a word of exactly 24 bits.
// - Format 01 gives 32 bits: code in top three bytes, zero low byte.
// - Upper format bit one: 25-bit signed code allowing overrange, in 32 bits.
// - 25-bit codings clamp positive overflow at the largest 25-bit code.
// - 25-bit codings clamp negative overflow at 0x1000000.
// - Inside one reference, 25-bit low 24 bits equal the 24-bit code.
// - Format 10 right-justifies the 25-bit code, top bits copy the sign.
// - Format 11 as 10, but top four bits carry the channel tag.
// - In manual multiplexer mode the channel tag reads 0000.
// - The formatted result sits in the result register at address 0x0.
// - The wide filter result is rounded to nearest, not truncated.
module adcrf_core
  import adcrf_pkg::*;
#(
  parameter int FILT_W = adcrf_pkg::ADCRF_FILT_W,
  parameter int FRAC_W = adcrf_pkg::ADCRF_FRAC_W
) (
  // Clock and reset
  input  wire logic                     core_clk,
  input  wire logic                     rst_b,
  // Filter result from the decimator
  input  wire logic                     smp_valid,
  input  wire adcrf_pkg::adcrf_sample_s smp,
  // Configuration
  input  wire adcrf_pkg::adcrf_fmt_e    data_format,
  // Readout from the serial side
  input  wire logic                     rd_start,
  input  wire logic                     rd_shift,
  // Result register and serial data
  output adcrf_pkg::adcrf_word_s        result,
  output logic                          result_valid,
  output logic [3:0]                    result_addr,
  output logic                          serial_bit,
  output logic                          rd_busy,
  output logic [5:0]                    bits_left
);

  import adcrf_pkg::*;

  localparam int ROUND_W = FILT_W - FRAC_W + 1;

  // Clamp a rounded value to the given 25-bit limits
  function automatic logic [24:0] clip(
    input logic signed [ROUND_W-1:0] v,
    input logic [24:0]               lim_hi,
    input logic [24:0]               lim_lo
  );
    logic signed [ROUND_W-1:0] hi;
    logic signed [ROUND_W-1:0] lo;
    hi = {{(ROUND_W-ADCRF_CODE25_W){lim_hi[24]}}, lim_hi};
    lo = {{(ROUND_W-ADCRF_CODE25_W){lim_lo[24]}}, lim_lo};
    if (v > hi) begin
      clip = lim_hi;
    end else if (v < lo) begin
      clip = lim_lo;
    end else begin
      clip = v[24:0];
    end
  endfunction

  // Readout may begin only from idle with a word held
  function automatic logic start_ok(
    input adcrf_shift_e st,
    input logic         req,
    input logic         have
  );
    start_ok = (st == ADCRF_SH_IDLE) && req && have;
  endfunction

  // Rounding stage
  logic signed [FILT_W:0]    round_sum;
  logic signed [ROUND_W-1:0] rounded;
  logic [24:0]               sat24;
  logic [24:0]               sat25;

  always_comb begin
    round_sum = {smp.filt[FILT_W-1], smp.filt}
              + {{(FILT_W-FRAC_W+1){1'b0}}, 1'b1, {(FRAC_W-1){1'b0}}};
    rounded   = round_sum[FILT_W:FRAC_W];
  end

  always_comb begin
    sat24 = clip(rounded, ADCRF_CODE24_MAX, ADCRF_CODE24_MIN);
    sat25 = clip(rounded, ADCRF_CODE25_MAX, ADCRF_CODE25_MIN);
  end

  // Saturated codes held until the result register is free
  logic [24:0] code24_q;
  logic [24:0] code25_q;
  logic [3:0]  tag_q;
  logic        pend_q;
  logic        load_word;

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      code24_q <= 25'h000_0000;
      code25_q <= 25'h000_0000;
      tag_q    <= ADCRF_TAG_MANUAL;
    end else if (smp_valid) begin
      code24_q <= sat24;
      code25_q <= sat25;
      tag_q    <= smp.scan_mode ? smp.converted_channel_tag : ADCRF_TAG_MANUAL;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      pend_q <= 1'b0;
    end else if (smp_valid) begin
      pend_q <= 1'b1;
    end else if (load_word) begin
      pend_q <= 1'b0;
    end
  end

  // Readout shifter state
  adcrf_shift_e sh_q;
  logic [31:0]  shreg_q;
  logic [5:0]   cnt_q;

  // A new word enters the register only while no readout runs
  assign load_word = pend_q && (sh_q == ADCRF_SH_IDLE);

  // Copies of the 25-bit sign for the top byte
  logic [6:0] sign_fill;

  for (genvar gi = 0; gi < 7; gi++) begin : g_sign_fill
    assign sign_fill[gi] = code25_q[24];
  end

  // Formatting, sampled from the format field at load time
  logic [31:0] fmt_data;
  logic        fmt_long;

  always_comb begin
    fmt_data = {ADCRF_PAD_BYTE, code24_q[23:0]};
    fmt_long = 1'b0;
    case (data_format)
      ADCRF_FMT_24: begin
        fmt_data = {ADCRF_PAD_BYTE, code24_q[23:0]};
        fmt_long = 1'b0;
      end
      ADCRF_FMT_32_LEFT: begin
        fmt_data = {code24_q[23:0], ADCRF_PAD_BYTE};
        fmt_long = 1'b1;
      end
      ADCRF_FMT_32_SIGN: begin
        fmt_data = {sign_fill, code25_q};
        fmt_long = 1'b1;
      end
      ADCRF_FMT_32_TAG: begin
        fmt_data = {tag_q, sign_fill[2:0], code25_q};
        fmt_long = 1'b1;
      end
      default: begin
        fmt_data = {ADCRF_PAD_BYTE, code24_q[23:0]};
        fmt_long = 1'b0;
      end
    endcase
  end

  // Conversion result register
  adcrf_word_s word_q;
  logic        word_valid_q;
  logic        rd_go;

  assign rd_go = start_ok(sh_q, rd_start, word_valid_q);

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      word_q <= '0;
    end else if (load_word) begin
      word_q.data      <= fmt_data;
      word_q.long_word <= fmt_long;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      word_valid_q <= 1'b0;
    end else if (load_word) begin
      word_valid_q <= 1'b1;
    end
  end

  // Readout: MSB first, 24 or 32 bits
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      sh_q <= ADCRF_SH_IDLE;
    end else begin
      case (sh_q)
        ADCRF_SH_IDLE: begin
          if (rd_go) begin
            sh_q <= ADCRF_SH_BUSY;
          end
        end
        ADCRF_SH_BUSY: begin
          if (rd_shift && (cnt_q == 6'h01)) begin
            sh_q <= ADCRF_SH_IDLE;
          end
        end
        default: begin
          sh_q <= ADCRF_SH_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      shreg_q <= 32'h0000_0000;
      cnt_q   <= 6'h00;
    end else if (rd_go) begin
      // 24-bit word is moved to the top so the sign leaves first
      shreg_q <= word_q.long_word ? word_q.data
                                  : {word_q.data[23:0], ADCRF_PAD_BYTE};
      cnt_q   <= word_q.long_word ? ADCRF_LEN32 : ADCRF_LEN24;
    end else if ((sh_q == ADCRF_SH_BUSY) && rd_shift) begin
      shreg_q <= {shreg_q[30:0], 1'b0};
      cnt_q   <= cnt_q - 6'h01;
    end
  end

  assign result       = word_q;
  assign result_valid = word_valid_q;
  assign result_addr  = ADCRF_RESULT_ADDR;
  assign serial_bit   = shreg_q[31];
  assign rd_busy      = (sh_q == ADCRF_SH_BUSY);
  assign bits_left    = cnt_q;

endmodule

//--- hw/adcrf_pkg.sv
package adcrf_pkg;

  // Internal filter result and rounding position
  localparam int ADCRF_FILT_W  = 40;
  localparam int ADCRF_FRAC_W  = 8;

  // Code and word sizes
  localparam int ADCRF_CODE24_W = 24;
  localparam int ADCRF_CODE25_W = 25;
  localparam int ADCRF_WORD_W   = 32;
  localparam int ADCRF_TAG_W    = 4;
  localparam int ADCRF_CNT_W    = 6;

  // Saturation limits
  localparam logic [24:0] ADCRF_CODE24_MAX = 25'h07F_FFFF;
  localparam logic [24:0] ADCRF_CODE24_MIN = 25'h180_0000;
  localparam logic [24:0] ADCRF_CODE25_MAX = 25'h0FF_FFFF;
  localparam logic [24:0] ADCRF_CODE25_MIN = 25'h100_0000;

  // Fill values and lengths
  localparam logic [7:0]  ADCRF_PAD_BYTE   = 8'h00;
  localparam logic [3:0]  ADCRF_TAG_MANUAL = 4'h0;
  localparam logic [5:0]  ADCRF_LEN24      = 6'h18;
  localparam logic [5:0]  ADCRF_LEN32      = 6'h20;

  // Location of the conversion result register
  localparam logic [3:0]  ADCRF_RESULT_ADDR = 4'h0;

  typedef enum logic [1:0] {
    ADCRF_FMT_24       = 2'b00,
    ADCRF_FMT_32_LEFT  = 2'b01,
    ADCRF_FMT_32_SIGN  = 2'b10,
    ADCRF_FMT_32_TAG   = 2'b11
  } adcrf_fmt_e;

  typedef enum logic [1:0] {
    ADCRF_SH_IDLE = 2'b01,
    ADCRF_SH_BUSY = 2'b10
  } adcrf_shift_e;

  typedef struct packed {
    logic signed [ADCRF_FILT_W-1:0] filt;
    logic [ADCRF_TAG_W-1:0]         converted_channel_tag;
    logic                           scan_mode;
  } adcrf_sample_s;

  typedef struct packed {
    logic [ADCRF_WORD_W-1:0] data;
    logic                    long_word;
  } adcrf_word_s;

endpackage

//--- tb/adcrf_host_model.sv
`timescale 1ns/1ps
module adcrf_host_model (
  // Clock and request
  input  wire logic        core_clk,
  input  wire logic        go,
  // Readout port
  input  wire logic        serial_bit,
  input  wire logic        rd_busy,
  output logic             rd_start,
  output logic             rd_shift,
  // Collected word
  output logic [31:0]      word,
  output logic [5:0]       nbits,
  output logic             done
);
  initial {rd_start, rd_shift, done, word, nbits} = '0;
  always @(posedge go) begin
    @(negedge core_clk) rd_start = 1'b1;
    @(negedge core_clk) rd_start = 1'b0;
    {word, nbits} = '0;
    while (rd_busy === 1'b1) begin
      word = {word[30:0], serial_bit};
      nbits = nbits + 6'h01;
      rd_shift = 1'b1;
      @(negedge core_clk);
      // Stall on every other bit; shift strobe stays up between back-to-back bits
      if (nbits[0]) begin
        rd_shift = 1'b0;
        @(negedge core_clk);
      end
    end
    rd_shift = 1'b0;
    done = 1'b1;
    @(negedge core_clk) done = 1'b0;
  end
endmodule

//--- tb/adcrf_core_checker.sv
`timescale 1ns/1ps
module adcrf_core_checker (
  input wire logic                     core_clk,
  input wire logic                     rst_b,
  input wire logic                     smp_valid,
  input wire adcrf_pkg::adcrf_sample_s smp,
  input wire adcrf_pkg::adcrf_fmt_e    data_format,
  input wire logic                     rd_start,
  input wire logic                     rd_shift,
  input wire adcrf_pkg::adcrf_word_s   result,
  input wire logic                     result_valid,
  input wire logic [3:0]               result_addr,
  input wire logic                     serial_bit,
  input wire logic                     rd_busy,
  input wire logic [5:0]               bits_left
);
  import adcrf_pkg::*;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  sequence s_load;
    smp_valid && !rd_busy ##1 !smp_valid && !rd_busy ##1 !rd_busy;
  endsequence
  a_addr_zero: assert property (result_addr == 4'h0)
    else $error("address not zero");
  a_len_follows: assert property (s_load |=> result.long_word == ($past(data_format) != 2'b00))
    else $error("length wrong");
  a_left_pad: assert property (s_load ##0 data_format == 2'b01 |=> result.data[7:0] == 8'h00)
    else $error("low byte not zero");
  a_sign_fill: assert property (s_load ##0 data_format == 2'b10 |=>
    result.data[31:25] == {7{result.data[24]}}) else $error("sign fill wrong");
  a_tag_field: assert property (s_load ##0 data_format == 2'b11 |=>
    result.data[31:28] == ($past(smp.scan_mode, 3) ? $past(smp.converted_channel_tag, 3) : 4'h0))
    else $error("tag wrong");
  a_start_msb: assert property (rd_start && !rd_busy && result_valid |=> rd_busy &&
    bits_left == (result.long_word ? 6'h20 : 6'h18) &&
    serial_bit == (result.long_word ? result.data[31] : result.data[23])) else $error("start wrong");
  a_shift_count: assert property (rd_busy && rd_shift && bits_left > 6'h01 |=> rd_busy &&
    bits_left == $past(bits_left) - 6'h01) else $error("count wrong");
  a_last_bit: assert property (rd_busy && rd_shift && bits_left == 6'h01 |=> !rd_busy &&
    bits_left == 6'h00) else $error("end wrong");
  a_word_hold: assert property (rd_busy && !rd_shift |=> $stable(serial_bit) && $stable(result))
    else $error("held word moved");
endmodule
bind adcrf_core adcrf_core_checker i_adcrf_core_checker (.core_clk(core_clk), .rst_b(rst_b),
  .smp_valid(smp_valid), .smp(smp), .data_format(data_format), .rd_start(rd_start),
  .rd_shift(rd_shift), .result(result), .result_valid(result_valid), .result_addr(result_addr),
  .serial_bit(serial_bit), .rd_busy(rd_busy), .bits_left(bits_left));

//--- tb/adc_result_formatter_tb.sv
`timescale 1ns/1ps
module adc_result_formatter_tb;
  import adcrf_pkg::*;
  logic          core_clk = 1'b0, rst_b = 1'b0, smp_valid = 1'b0, go = 1'b0;
  adcrf_sample_s smp = '0;
  adcrf_fmt_e    data_format = ADCRF_FMT_24;
  adcrf_word_s   result;
  logic          rd_start, rd_shift, result_valid, serial_bit, rd_busy, done;
  logic [3:0]    result_addr;
  logic [5:0]    bits_left, nbits;
  logic [31:0]   word, rnd = 32'h0000_cdc6;
  logic [32:0]   expq[$];
  logic [39:0]   pat[8] = '{40'h0, 40'h00_8000_0000, 40'hFF_7FFF_FF00, 40'h00_FFFF_FF80,
                            40'hFF_0000_0000, 40'h80_0000_0000, 40'h00_0000_0580, 40'hFF_FFFF_FA80};
  int            n_mismatch = 0, n_checks = 0;
  always #4 core_clk = ~core_clk;
  adcrf_core i_adcrf_core (.core_clk(core_clk), .rst_b(rst_b), .smp_valid(smp_valid), .smp(smp),
    .data_format(data_format), .rd_start(rd_start), .rd_shift(rd_shift), .result(result),
    .result_valid(result_valid), .result_addr(result_addr), .serial_bit(serial_bit),
    .rd_busy(rd_busy), .bits_left(bits_left));
  adcrf_host_model i_adcrf_host_model (.core_clk(core_clk), .go(go), .serial_bit(serial_bit),
    .rd_busy(rd_busy), .rd_start(rd_start), .rd_shift(rd_shift), .word(word), .nbits(nbits),
    .done(done));
  function automatic logic [31:0] lfsr(logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  function automatic logic [32:0] expect_word(adcrf_sample_s s, logic [1:0] fm);
    logic signed [39:0] r;
    logic [24:0]        c;
    r = ($signed(s.filt) + 40'sh00_0000_0080) >>> 8;
    if (fm[1]) c = ($signed(r[24:0]) == r) ? r[24:0] : (r[39] ? 25'h100_0000 : 25'h0FF_FFFF);
    else c = ($signed(r[23:0]) == r) ? r[24:0] : (r[39] ? 25'h180_0000 : 25'h07F_FFFF);
    case (fm)
      2'b00: return {1'b0, 8'h00, c[23:0]};
      2'b01: return {1'b1, c[23:0], 8'h00};
      2'b10: return {1'b1, {7{c[24]}}, c};
      default: return {1'b1, s.scan_mode ? s.converted_channel_tag : 4'h0, {3{c[24]}}, c};
    endcase
  endfunction
  task automatic chk(string name, logic [32:0] e, logic [32:0] g);
    n_checks++;
    if (e !== g) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", name, e, g);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // Each finished readout is judged against the oldest note
  always @(posedge done) begin
    logic [32:0] e;
    e = expq.size() ? expq.pop_front() : 33'h0;
    chk("serial word", e, {nbits == 6'h20, word});
    chk("result word", e, {result.long_word, result.data});
    chk("result valid", 33'h1, {32'h0, result_valid});
  end
  initial begin
    repeat (16) @(posedge core_clk);
    @(negedge core_clk) rst_b = 1'b1;
    for (int k = 0; k < 40; k++) begin
      @(negedge core_clk);
      rnd = lfsr(rnd);
      data_format = adcrf_fmt_e'(k[1:0]);
      smp.converted_channel_tag = rnd[3:0];
      smp.scan_mode = rnd[4];
      smp.filt = (k[4:2] == 3'h0) ? {{8{rnd[31]}}, rnd} : pat[k[4:2]];
      expq.push_back(expect_word(smp, k[1:0]));
      smp_valid = 1'b1;
      @(negedge core_clk) smp_valid = 1'b0;
      repeat (2) @(negedge core_clk);
      go = 1'b1;
      @(negedge core_clk) go = 1'b0;
      // Format moves while the word is shifted out
      data_format = adcrf_fmt_e'(rnd[6:5]);
      @(posedge done);
      @(negedge core_clk);
    end
    tally_and_finish();
  end
  initial begin
    #40_000;
    n_mismatch++;
    tally_and_finish();
  end
endmodule
